// ### asr_pkg.sv
// package: constants and types for the static memory host controller
package asr_pkg;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 16;
   localparam int LANE_W = 8;
   localparam int CLK_NS = 100;
   localparam int FIRST_ACCESS_US = 150;
   localparam int FIRST_ACCESS_CYC = (FIRST_ACCESS_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int ADDR_ACCESS_NS = 15;
   localparam int ADDR_ACCESS_CYC = (ADDR_ACCESS_NS + CLK_NS - 1) / CLK_NS;
   localparam int WRITE_SETUP_NS = 10;
   localparam int WRITE_CYC = (WRITE_SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 16;

   typedef struct packed {
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [1:0] lanes_n;
      logic [DATA_W-1:0] wdata;
   } asr_req_t;

   typedef struct packed {
      logic select_active_low;
      logic select_active_high;
      logic drive_enable_n;
      logic write_strobe_n;
      logic low_lane_strobe_n;
      logic high_lane_strobe_n;
   } asr_ctl_t;

   localparam asr_ctl_t CTL_IDLE = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
endpackage : asr_pkg

// ### asr_delay.sv
// down counter that marks when a programmed number of cycles has passed
`timescale 1ns/10ps
module asr_delay #(
   parameter int WIDTH = 16
) (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic load_in,
   input wire logic [WIDTH-1:0] count_in,
   output logic done_out
);
   logic [WIDTH-1:0] cnt_q;
   logic [WIDTH-1:0] cnt_d;
   wire zero = (cnt_q == '0);
   assign cnt_d = load_in ? count_in : (zero ? cnt_q : cnt_q - WIDTH'(1));
   assign done_out = zero & ~load_in;

   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
         cnt_q <= '0;
      else
         cnt_q <= cnt_d;
   end
endmodule : asr_delay

// ### asr_host.sv
// host controller driving an asynchronous 1M x 16 static memory
`timescale 1ns/10ps
module asr_host #(
   parameter int FIRST_ACCESS_CYCLES = asr_pkg::FIRST_ACCESS_CYC,
   parameter int READ_CYCLES = asr_pkg::ADDR_ACCESS_CYC,
   parameter int WRITE_CYCLES = asr_pkg::WRITE_CYC
) (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic req_valid_in,
   input wire asr_pkg::asr_req_t req_in,
   output logic req_ready_out,
   output logic rsp_valid_out,
   output logic [asr_pkg::DATA_W-1:0] rsp_data_out,
   output logic ready_out,
   output logic [asr_pkg::ADDR_W-1:0] word_address_out,
   output asr_pkg::asr_ctl_t ctl_out,
   input wire logic [asr_pkg::DATA_W-1:0] data_in,
   output logic [asr_pkg::DATA_W-1:0] data_out,
   output logic data_oe_out
);
   // refuse cycle counts that the delay counter cannot hold
   if (FIRST_ACCESS_CYCLES < 1 || FIRST_ACCESS_CYCLES >= (1 << asr_pkg::CNT_W))
   begin : g_bad_first
      $error("first access cycle count out of range");
   end

   if (READ_CYCLES < 1 || READ_CYCLES >= (1 << asr_pkg::CNT_W))
   begin : g_bad_read
      $error("read cycle count out of range");
   end

   if (WRITE_CYCLES < 1 || WRITE_CYCLES >= (1 << asr_pkg::CNT_W))
   begin : g_bad_write
      $error("write cycle count out of range");
   end

   typedef enum logic [2:0] {
      ASR_POWER_UP,
      ASR_IDLE,
      ASR_READ,
      ASR_WRITE,
      ASR_WRITE_END
   } asr_state_t;

   asr_state_t state_q;
   asr_state_t state_d;
   asr_pkg::asr_req_t cur_q;
   asr_pkg::asr_req_t cur_d;
   logic [asr_pkg::DATA_W-1:0] rdata_q;
   logic [asr_pkg::DATA_W-1:0] rdata_d;
   logic rsp_q;
   logic rsp_d;
   logic armed_q;
   logic armed_d;
   logic load;
   logic [asr_pkg::CNT_W-1:0] load_cnt;
   logic done;

   // state decode
   wire in_power_up = (state_q == ASR_POWER_UP);
   wire in_idle = (state_q == ASR_IDLE);
   wire in_read = (state_q == ASR_READ);
   wire in_write = (state_q == ASR_WRITE);
   wire in_write_end = (state_q == ASR_WRITE_END);
   wire selected = in_read | in_write;

   // request and end-of-phase decode
   wire take = in_idle & req_valid_in;
   wire take_write = take & req_in.write;
   wire read_last = in_read & done;
   wire write_last = in_write & done;
   wire power_up_last = in_power_up & armed_q & done;

   // disabled lanes read as zero
   wire [asr_pkg::DATA_W-1:0] lane_mask = {{asr_pkg::LANE_W{~cur_q.lanes_n[1]}},
                                           {asr_pkg::LANE_W{~cur_q.lanes_n[0]}}};

   // power-up count loads on the first cycle out of reset, so the wait really runs
   assign load = (in_power_up & ~armed_q) | take;
   assign load_cnt = in_power_up ? asr_pkg::CNT_W'(FIRST_ACCESS_CYCLES)
                   : take_write ? asr_pkg::CNT_W'(WRITE_CYCLES)
                   : asr_pkg::CNT_W'(READ_CYCLES);

   asr_delay #(.WIDTH(asr_pkg::CNT_W)) u_delay (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .load_in(load),
      .count_in(load_cnt),
      .done_out(done)
   );

   // power-up wait then request sequencing
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ASR_POWER_UP:
         begin
            if (power_up_last)
               state_d = ASR_IDLE;
         end
         ASR_IDLE:
         begin
            if (take)
               state_d = take_write ? ASR_WRITE : ASR_READ;
         end
         ASR_READ:
         begin
            if (read_last)
               state_d = ASR_IDLE;
         end
         ASR_WRITE:
         begin
            if (write_last)
               state_d = ASR_WRITE_END;
         end
         ASR_WRITE_END:
         begin
            state_d = ASR_IDLE;
         end
         default:
         begin
            state_d = ASR_POWER_UP;
         end
      endcase
   end

   // next values of the data registers
   assign armed_d = in_power_up;
   assign cur_d = take ? req_in : cur_q;
   // sample while still enabled, before address moves
   assign rdata_d = read_last ? (data_in & lane_mask) : rdata_q;
   assign rsp_d = read_last;

   // request side
   assign req_ready_out = in_idle;
   assign ready_out = ~in_power_up;
   assign rsp_valid_out = rsp_q;
   assign rsp_data_out = rdata_q;

   // memory side
   assign word_address_out = cur_q.addr;
   assign data_out = cur_q.wdata;
   // drive data during the write strobe and one cycle after it, never during reads
   assign data_oe_out = in_write | in_write_end;
   // selects active only during an access, standby otherwise
   assign ctl_out.select_active_low = ~selected;
   assign ctl_out.select_active_high = selected;
   assign ctl_out.drive_enable_n = ~in_read;
   assign ctl_out.write_strobe_n = ~in_write;
   assign ctl_out.low_lane_strobe_n = ~selected | cur_q.lanes_n[0];
   assign ctl_out.high_lane_strobe_n = ~selected | cur_q.lanes_n[1];

   // sequencer state
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
         state_q <= ASR_POWER_UP;
      else
         state_q <= state_d;
   end

   // marks that the power-up count has been loaded
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
         armed_q <= 1'b0;
      else
         armed_q <= armed_d;
   end

   // request capture
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
         cur_q <= '0;
      else
         cur_q <= cur_d;
   end

   // read data and response pulse
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         rdata_q <= '0;
         rsp_q <= 1'b0;
      end
      else
      begin
         rdata_q <= rdata_d;
         rsp_q <= rsp_d;
      end
   end
endmodule : asr_host

// ### asr_sram_model.sv
// behavioural 1M x 16 static memory at the far side of the host
`timescale 1ns/10ps
module asr_sram_model (
   input wire logic [19:0] a_in,
   input wire asr_pkg::asr_ctl_t c_in,
   input wire logic [15:0] d_in,
   output logic [15:0] q_out
);
   logic [15:0] mem [0:1048575];
   wire sel = !c_in.select_active_low && c_in.select_active_high;
   wire rd = sel && !c_in.drive_enable_n && c_in.write_strobe_n;
   wire hi = rd && !c_in.high_lane_strobe_n;
   wire lo = rd && !c_in.low_lane_strobe_n;
   always @*
      if (sel && !c_in.write_strobe_n)
      begin
         if (!c_in.low_lane_strobe_n) mem[a_in][7:0] = d_in[7:0];
         if (!c_in.high_lane_strobe_n) mem[a_in][15:8] = d_in[15:8];
      end
   // undriven lanes show the inverse of the stored byte
   assign #7 q_out = mem[a_in] ^ ~{{8{hi}}, {8{lo}}};
endmodule : asr_sram_model

// ### asr_host_monitor.sv
// checker of the host pin and request timing
`timescale 1ns/10ps
module asr_host_monitor (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic req_valid_in,
   input wire asr_pkg::asr_req_t req_in,
   input wire logic req_ready_out,
   input wire logic rsp_valid_out,
   input wire logic [15:0] rsp_data_out,
   input wire logic ready_out,
   input wire logic [19:0] word_address_out,
   input wire asr_pkg::asr_ctl_t ctl_out,
   input wire logic [15:0] data_in,
   input wire logic [15:0] data_out,
   input wire logic data_oe_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   wire sel = !ctl_out.select_active_low && ctl_out.select_active_high;
   wire we_n = ctl_out.write_strobe_n;
   wire oe_n = ctl_out.drive_enable_n;
   wire [1:0] ln = {ctl_out.high_lane_strobe_n, ctl_out.low_lane_strobe_n};
   wire tk = req_valid_in && req_ready_out;
   a_write_selected: assert property (!we_n |-> sel)
      else $error("write strobe unselected");
   a_read_strobe_high: assert property (!oe_n |-> we_n && sel)
      else $error("read with write strobe");
   a_read_no_drive: assert property (!oe_n |-> !data_oe_out)
      else $error("host drives during read");
   a_idle_before_ready: assert property (!ready_out |-> !sel)
      else $error("access before ready");
   a_read_walk: assert property (tk && !req_in.write |=> !oe_n &&
      word_address_out == $past(req_in.addr) ##1 !oe_n ##1 rsp_valid_out)
      else $error("read walk");
   a_write_walk: assert property (tk && req_in.write |=> !we_n && data_oe_out &&
      word_address_out == $past(req_in.addr) ##1 !we_n ##1 we_n && !sel && data_oe_out)
      else $error("write walk");
   a_write_lanes: assert property (tk && req_in.write |=> ln == $past(req_in.lanes_n)
      && data_out == $past(req_in.wdata)) else $error("write lanes");
   a_read_lanes: assert property (rsp_valid_out |-> rsp_data_out ==
      ($past(data_in) & ~{{8{$past(ln[1])}}, {8{$past(ln[0])}}})) else $error("read lanes");
   c_read: cover property (tk && !req_in.write);
   c_write: cover property (tk && req_in.write);
   c_part: cover property (!oe_n && ln != 2'h0);
endmodule : asr_host_monitor
bind asr_host asr_host_monitor mon (.clk_sys_in, .rst_in, .req_valid_in, .req_in,
   .req_ready_out, .rsp_valid_out, .rsp_data_out, .ready_out, .word_address_out,
   .ctl_out, .data_in, .data_out, .data_oe_out);

// ### asr_host_tb.sv
// self-checking bench for the static memory host controller
`timescale 1ns/10ps
module asr_host_tb;
   logic clk_sys_in = 1'b0, rst_in = 1'b1, req_valid_in = 1'b0;
   asr_pkg::asr_req_t req_in = '0;
   logic req_ready_out, rsp_valid_out, ready_out, data_oe_out;
   logic [15:0] rsp_data_out, data_in, data_out, d, sh [8];
   logic [19:0] word_address_out, at [8];
   logic [1:0] l;
   asr_pkg::asr_ctl_t ctl_out;
   int seed = 8925, n_mismatch = 0, checks = 0, i, k, n;
   localparam int FA = 4;
   initial forever #50 clk_sys_in = ~clk_sys_in;
   asr_host #(.FIRST_ACCESS_CYCLES(FA)) dut (.clk_sys_in, .rst_in, .req_valid_in, .req_in,
      .req_ready_out, .rsp_valid_out, .rsp_data_out, .ready_out, .word_address_out,
      .ctl_out, .data_in, .data_out, .data_oe_out);
   asr_sram_model mem (.a_in(word_address_out), .c_in(ctl_out), .d_in(data_out),
      .q_out(data_in));
   function automatic logic [15:0] mrg(input logic [15:0] o, w, input logic [1:0] s);
      return {s[1] ? o[15:8] : w[15:8], s[0] ? o[7:0] : w[7:0]};
   endfunction : mrg
   task automatic cmp(input logic [15:0] g, e);
      checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("MISMATCH %0t read data %h not %h", $time, g, e);
      end
   endtask : cmp
   task automatic cmp_flag(input logic ok, input string what);
      checks++;
      if (ok !== 1'b1)
      begin
         n_mismatch++;
         $display("MISMATCH %0t %s", $time, what);
      end
   endtask : cmp_flag
   task automatic acc(input logic w, input logic [19:0] a, input logic [1:0] s,
      input logic [15:0] v);
      @(negedge clk_sys_in);
      req_in = '{w, a, s, v};
      req_valid_in = 1'b1;
      for (n = 0; n < 99 && req_ready_out !== 1'b1; n++) @(negedge clk_sys_in);
      cmp_flag(n < 99, "request never taken");
      @(negedge clk_sys_in);
      req_valid_in = 1'b0;
   endtask : acc
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : summarize
   initial
   begin
      #(3000 * asr_pkg::CLK_NS);
      n_mismatch++;
      summarize();
   end
   initial
   begin
      repeat (16) @(negedge clk_sys_in);
      rst_in = 1'b0;
      for (i = 0; i < 8; i++)
      begin
         at[i] = (i == 7) ? 20'hFFFFF : {i[2:0], 17'h00000};
         sh[i] = 16'($random(seed));
         acc(1'b1, at[i], 2'h0, sh[i]);
         if (i == 0) cmp_flag(n >= FA && n < FA + 4, "power-up wait");
      end
      $display("test fill done");
      for (i = 0; i < 80; i++)
      begin
         k = $unsigned($random(seed)) % 8;
         l = 2'($random(seed));
         d = 16'($random(seed));
         if (d[0])
         begin
            acc(1'b1, at[k], l, d);
            sh[k] = mrg(sh[k], d, l);
         end
         else
         begin
            acc(1'b0, at[k], l, 16'h0000);
            for (n = 0; n < 9 && rsp_valid_out !== 1'b1; n++) @(negedge clk_sys_in);
            cmp_flag(rsp_valid_out === 1'b1, "no read response");
            cmp(rsp_data_out, mrg(16'h0000, sh[k], l));
         end
      end
      $display("test random done");
      summarize();
   end
endmodule : asr_host_tb
